/* rtl/hbf_host.sv */
`timescale 1ns/10ps
module hbf_host (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic req_i,
   input wire hbf_pkg::hbf_op_t op_i,
   input wire logic [19:0] addr_i,
   input wire logic [7:0] cmd_i,
   input wire logic [15:0] wdata_i,
   input wire logic pd_req_i,
   input wire logic byte_mode_i,
   input wire logic id_mode_i,
   input wire logic boot_unlock_hv_i,
   input wire logic boot_unlock_i,
   output logic ready_o,
   output logic [15:0] rdata_o,
   output logic rdata_valid_o,
   output logic ce_n_o,
   output logic oe_n_o,
   output logic we_n_o,
   output logic [18:0] addr_o,
   output logic [15:0] dq_o,
   output logic [15:0] dq_oe_n_o,
   input wire logic [15:0] dq_i,
   output logic reset_powerdown_n_o,
   output logic rp_hv_en_o,
   output logic id_hv_en_o,
   output logic byte_n_o,
   output logic boot_guard_n_o
);
   import hbf_pkg::*;

   hbf_state_t state_r;
   logic ce_n_r, oe_n_r, we_n_r, rp_n_r;
   logic ld_r;
   logic [TMR_W-1:0] val_r;
   logic second_r;
   logic tmr_done;
   logic rvalid_r;
   logic [15:0] rdata_r;
   logic [18:0] addr_r;
   logic a_m1_r;
   logic [15:0] dq_r;
   logic [15:0] wdata_r;
   logic drv_r;
   logic byte_r;
   logic [15:0] dq_s1_r, dq_s2_r;
   logic rp_hv_r, id_hv_r, guard_n_r;
   logic [TMR_W-1:0] since_r;

   hbf_timer hbf_timer_inst (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .load_i(ld_r),
      .value_i(val_r),
      .done_o(tmr_done)
   );

   // Sequencing of bus strobes and the reset pin
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         state_r <= S_PD;
         ce_n_r <= 1'b1;
         oe_n_r <= 1'b1;
         we_n_r <= 1'b1;
         rp_n_r <= 1'b0;
         ld_r <= 1'b1;
         val_r <= TMR_W'(PD_CYC);
         second_r <= 1'b0;
         rvalid_r <= 1'b0;
      end else begin
         ld_r <= 1'b0;
         rvalid_r <= 1'b0;
         unique case (state_r)
            S_PD: begin
               if (tmr_done && !pd_req_i) begin
                  rp_n_r <= 1'b1;
                  ld_r <= 1'b1;
                  val_r <= TMR_W'(WAKE_WAIT);
                  state_r <= S_WAKE;
               end
            end
            S_WAKE: begin
               if (pd_req_i) begin
                  rp_n_r <= 1'b0;
                  ld_r <= 1'b1;
                  val_r <= TMR_W'(PD_CYC);
                  state_r <= S_PD;
               end else if (tmr_done) begin
                  state_r <= S_IDLE;
               end
            end
            S_IDLE: begin
               if (pd_req_i) begin
                  rp_n_r <= 1'b0;
                  ld_r <= 1'b1;
                  val_r <= TMR_W'(PD_CYC);
                  state_r <= S_PD;
               end else if (req_i) begin
                  ce_n_r <= 1'b0;
                  ld_r <= 1'b1;
                  if (op_i == HBF_OP_READ) begin
                     oe_n_r <= 1'b0;
                     val_r <= TMR_W'(RD_CYC);
                     state_r <= S_RD;
                  end else begin
                     we_n_r <= 1'b0;
                     val_r <= TMR_W'(WE_LO_CYC);
                     second_r <= (op_i == HBF_OP_PROG);
                     state_r <= S_WR_LO;
                  end
               end
            end
            S_RD: begin
               if (tmr_done) begin
                  ce_n_r <= 1'b1;
                  oe_n_r <= 1'b1;
                  rvalid_r <= 1'b1;
                  state_r <= S_IDLE;
               end
            end
            S_WR_LO: begin
               if (tmr_done) begin
                  we_n_r <= 1'b1;
                  ld_r <= 1'b1;
                  val_r <= TMR_W'(WE_HI_CYC);
                  state_r <= S_WR_HI;
               end
            end
            S_WR_HI: begin
               if (tmr_done) begin
                  if (second_r) begin
                     // Chip select stays low; the data cycle follows the command
                     second_r <= 1'b0;
                     we_n_r <= 1'b0;
                     ld_r <= 1'b1;
                     val_r <= TMR_W'(WE_LO_CYC);
                     state_r <= S_WR_LO;
                  end else begin
                     ce_n_r <= 1'b1;
                     state_r <= S_IDLE;
                  end
               end
            end
         endcase
      end
   end

   // Address and write data; the device latches them on the strobe rise
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         addr_r <= '0;
         a_m1_r <= 1'b0;
         dq_r <= '0;
         wdata_r <= '0;
         drv_r <= 1'b0;
      end else if (state_r == S_IDLE && req_i && !pd_req_i) begin
         addr_r <= byte_r ? addr_i[19:1] : addr_i[18:0];
         a_m1_r <= addr_i[0];
         wdata_r <= byte_r ? {8'h00, wdata_i[7:0]} : wdata_i;
         dq_r <= {CMD_PAD, cmd_i};
         drv_r <= (op_i != HBF_OP_READ);
      end else if (state_r == S_WR_HI && tmr_done) begin
         dq_r <= wdata_r;
         drv_r <= second_r;
      end
   end

   // Pin inputs cross into the clock domain before use
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         dq_s1_r <= '0;
         dq_s2_r <= '0;
         rdata_r <= '0;
      end else begin
         dq_s1_r <= dq_i;
         dq_s2_r <= dq_s1_r;
         if (state_r == S_RD && tmr_done) begin
            rdata_r <= byte_r ? {8'h00, dq_s2_r[7:0]} : dq_s2_r;
         end
      end
   end

   // Width only changes while the device is powered down
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         byte_r <= 1'b0;
      end else if (state_r == S_PD) begin
         byte_r <= byte_mode_i;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         rp_hv_r <= 1'b0;
         id_hv_r <= 1'b0;
         guard_n_r <= 1'b0;
      end else begin
         rp_hv_r <= boot_unlock_hv_i && rp_n_r;
         id_hv_r <= id_mode_i;
         guard_n_r <= boot_unlock_i;
      end
   end

   // Cycles since reset pin release, saturating; used by the checks
   always_ff @(posedge clock_i) begin
      if (!rst_n_i || !rp_n_r) begin
         since_r <= '0;
      end else if (since_r != {TMR_W{1'b1}}) begin
         since_r <= since_r + 1'b1;
      end
   end

   assign ready_o = (state_r == S_IDLE) && !pd_req_i;
   assign rdata_o = rdata_r;
   assign rdata_valid_o = rvalid_r;
   assign ce_n_o = ce_n_r;
   assign oe_n_o = oe_n_r;
   assign we_n_o = we_n_r;
   assign addr_o = addr_r;
   assign dq_o = {byte_r ? a_m1_r : dq_r[15], dq_r[14:0]};
   assign dq_oe_n_o[7:0] = {8{!drv_r}};
   assign dq_oe_n_o[14:8] = {7{!(drv_r && !byte_r)}};
   assign dq_oe_n_o[15] = byte_r ? !rp_n_r : !drv_r;
   assign reset_powerdown_n_o = rp_n_r;
   assign rp_hv_en_o = rp_hv_r;
   assign id_hv_en_o = id_hv_r;
   assign byte_n_o = !byte_r;
   assign boot_guard_n_o = guard_n_r;

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);

   strobe_excl_a: assert property (!(!we_n_r && !oe_n_r))
      else $error("write and output enable both low");
   read_free_a: assert property (!oe_n_r |-> (&dq_oe_n_o[14:0]))
      else $error("host drives data while output enable low");
   pd_follow_a: assert property (state_r == S_IDLE && pd_req_i |=> !rp_n_r)
      else $error("reset pin did not follow power-down request");
   wake_write_a: assert property (!we_n_r |-> since_r >= TMR_W'(WAKE_CYC))
      else $error("write strobe before wake delay");
   recov_read_a: assert property (rvalid_r |-> since_r >= TMR_W'(RECOV_CYC))
      else $error("read data before recovery time");
   width_hold_a: assert property (rp_n_r && $past(rp_n_r) |-> $stable(byte_r))
      else $error("width changed outside power-down");
   prog_second_a: assert property (state_r == S_WR_HI && second_r && tmr_done
      |=> !we_n_r && !ce_n_r && dq_r == wdata_r)
      else $error("program data cycle missing");
   we_pulse_a: assert property ($fell(we_n_r) |-> (!we_n_r && !ce_n_r && drv_r)[*3])
      else $error("write pulse too short or unselected");
endmodule

/* rtl/hbf_pkg.sv */
package hbf_pkg;
   localparam int CLK_NS = 25;
   // Bus timing figures; plain defaults, tune to the part on the board
   localparam int READ_ACC_NS = 100;
   localparam int WE_LOW_NS = 50;
   localparam int WE_HIGH_NS = 30;
   localparam int PD_MIN_NS = 100;
   localparam int RECOVERY_NS = 300;
   localparam int WAKE_NS = 300;
   localparam int SYNC_LAT = 2;
   localparam int TMR_W = 12;

   function automatic int cyc_up(input int ns);
      int c;
      c = (ns + CLK_NS - 1) / CLK_NS;
      return (c < 1) ? 1 : c;
   endfunction

   localparam int RD_CYC = cyc_up(READ_ACC_NS) + SYNC_LAT;
   localparam int WE_LO_CYC = cyc_up(WE_LOW_NS);
   localparam int WE_HI_CYC = cyc_up(WE_HIGH_NS);
   localparam int PD_CYC = cyc_up(PD_MIN_NS);
   localparam int RECOV_CYC = cyc_up(RECOVERY_NS);
   localparam int WAKE_CYC = cyc_up(WAKE_NS);
   localparam int WAKE_WAIT = (RECOV_CYC > WAKE_CYC) ? RECOV_CYC : WAKE_CYC;
   localparam logic [7:0] CMD_PAD = 8'h00;

   typedef enum logic [1:0] {HBF_OP_READ, HBF_OP_CMD, HBF_OP_PROG} hbf_op_t;
   typedef enum logic [2:0] {S_PD, S_WAKE, S_IDLE, S_RD, S_WR_LO, S_WR_HI} hbf_state_t;
endpackage

/* rtl/hbf_timer.sv */
`timescale 1ns/10ps
module hbf_timer (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic load_i,
   input wire logic [hbf_pkg::TMR_W-1:0] value_i,
   output logic done_o
);
   import hbf_pkg::*;
   logic [TMR_W-1:0] cnt_r;

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         cnt_r <= '0;
      end else if (load_i) begin
         cnt_r <= value_i;
      end else if (cnt_r != '0) begin
         cnt_r <= cnt_r - 1'b1;
      end
   end

   // A load in flight hides the stale zero of the previous interval
   assign done_o = (cnt_r == '0) && !load_i;
endmodule

/* verif/hbf_flash_model.sv */
`timescale 1ns/10ps
module hbf_flash_model #(
   parameter logic [7:0] PROG_CMD = 8'h40,
   parameter logic [15:0] MFR_CODE = 16'h7E21, // Arbitrary value
   parameter logic [15:0] DEV_CODE = 16'h39B4, // Arbitrary value
   parameter int WAKE_NS = 300,
   // Top of the small model array stands in for the boot block
   parameter logic [7:0] BOOT_BASE = 8'hF0
) (
   input wire logic ce_n_i,
   input wire logic oe_n_i,
   input wire logic we_n_i,
   input wire logic [18:0] addr_i,
   input wire logic [15:0] dq_i,
   input wire logic rp_n_i,
   input wire logic id_hv_i,
   input wire logic byte_n_i,
   input wire logic rp_hv_i,
   input wire logic guard_n_i,
   input wire logic vpp_low_i,
   output logic [15:0] dq_o
);
   logic [15:0] mem [0:255];
   logic [15:0] last_q = 16'h0000;
   logic [15:0] rd;
   logic [7:0] last_cmd = 8'h00;
   logic prog_armed = 1'b0;
   logic word_w = 1'b1;
   logic drive;
   time wake_t = 0;
   int early_writes = 0;
   int refused = 0;
   logic [7:0] status_w = 8'h00;
   logic rp_q = 1'b0;
   initial for (int i = 0; i < 256; i++) mem[i] = 16'hFFFF;
   // One process owns the write state, so reset pin and strobe edges never race
   always @(posedge we_n_i or rp_n_i) begin
      if (rp_n_i !== 1'b1) begin
         prog_armed = 1'b0;
         status_w = 8'h00;
      end else if (rp_q !== 1'b1) begin
         prog_armed = 1'b0;
         word_w = byte_n_i;
         wake_t = $time;
      end else if (!ce_n_i) begin
         if ($time - wake_t < WAKE_NS) early_writes++;
         else if (prog_armed) begin
            prog_armed = 1'b0;
            if (vpp_low_i) begin
               refused++;
            end else if (addr_i[7:0] >= BOOT_BASE && !guard_n_i && !rp_hv_i) begin
               status_w[4] = 1'b1;
            end else if (word_w) begin
               mem[addr_i[7:0]] = dq_i;
            end else if (dq_i[15]) begin
               mem[addr_i[7:0]][15:8] = dq_i[7:0];
            end else begin
               mem[addr_i[7:0]][7:0] = dq_i[7:0];
            end
         end else begin
            last_cmd = dq_i[7:0];
            prog_armed = (dq_i[7:0] == PROG_CMD);
         end
      end
      rp_q = rp_n_i;
   end
   always @* begin
      if (id_hv_i) rd = addr_i[0] ? DEV_CODE : MFR_CODE;
      else rd = mem[addr_i[7:0]];
      if (!word_w && (id_hv_i || !dq_i[15])) rd = {8'h00, rd[7:0]};
      else if (!word_w) rd = {8'h00, rd[15:8]};
   end
   assign drive = !ce_n_i && !oe_n_i && rp_n_i;
   always @(rd or drive) if (drive) last_q <= rd;
   // Floating lines show the inverse of last_q, the last rd seen while driving, never last_q itself
   assign dq_o = drive ? (word_w ? rd : {~addr_i[7:0], rd[7:0]}) : ~last_q;
endmodule

/* verif/tb_hbf_host.sv */
`timescale 1ns/10ps
module tb_hbf_host;
   import hbf_pkg::*;
   logic clock_i = 0, rst_n_i = 0, req_i = 0, pd_req_i = 0, byte_mode_i = 0, id_mode_i = 0;
   logic unl_hv = 0, unl = 0, ready_o, rdata_valid_o, ce_n_o, oe_n_o, we_n_o, rp_n, rp_hv, id_hv;
   logic byte_n_o, guard_n, vpp_low = 0;
   hbf_op_t op_i = HBF_OP_READ;
   logic [19:0] addr_i = 20'h00000;
   logic [7:0] cmd_i = 8'h00;
   logic [15:0] wdata_i = 16'h0000, rdata_o, dq_o, dq_oe_n_o, dq_dev, dq_w, rv;
   logic [18:0] addr_o;
   int fails = 0, n_compared = 0;
   always #12.5 clock_i = ~clock_i;
   assign dq_w = (~dq_oe_n_o & dq_o) | (dq_oe_n_o & dq_dev);
   hbf_host hbf_host_inst (.clock_i(clock_i), .rst_n_i(rst_n_i), .req_i(req_i), .op_i(op_i),
      .addr_i(addr_i), .cmd_i(cmd_i), .wdata_i(wdata_i), .pd_req_i(pd_req_i),
      .byte_mode_i(byte_mode_i), .id_mode_i(id_mode_i), .boot_unlock_hv_i(unl_hv),
      .boot_unlock_i(unl), .ready_o(ready_o), .rdata_o(rdata_o), .rdata_valid_o(rdata_valid_o),
      .ce_n_o(ce_n_o), .oe_n_o(oe_n_o), .we_n_o(we_n_o), .addr_o(addr_o), .dq_o(dq_o),
      .dq_oe_n_o(dq_oe_n_o), .dq_i(dq_w), .reset_powerdown_n_o(rp_n), .rp_hv_en_o(rp_hv),
      .id_hv_en_o(id_hv), .byte_n_o(byte_n_o), .boot_guard_n_o(guard_n));
   hbf_flash_model #(.WAKE_NS(WAKE_NS)) hbf_flash_model_inst (.ce_n_i(ce_n_o), .oe_n_i(oe_n_o),
      .we_n_i(we_n_o), .addr_i(addr_o), .dq_i(dq_w), .rp_n_i(rp_n), .id_hv_i(id_hv),
      .byte_n_i(byte_n_o), .rp_hv_i(rp_hv), .guard_n_i(guard_n), .vpp_low_i(vpp_low),
      .dq_o(dq_dev));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wait_rdy();
      int n = 0;
      while (ready_o !== 1'b1 && n < 400) begin
         @(negedge clock_i);
         n++;
      end
      chk(16'(n < 400), 16'h0001);
   endtask
   task automatic run(input hbf_op_t o, input logic [19:0] a, input logic [15:0] d);
      int n = 0;
      wait_rdy();
      req_i = 1;
      op_i = o;
      addr_i = a;
      cmd_i = (o == HBF_OP_CMD) ? d[7:0] : hbf_flash_model_inst.PROG_CMD;
      wdata_i = d;
      @(negedge clock_i);
      req_i = 0;
      while (o == HBF_OP_READ && rdata_valid_o !== 1'b1 && n < 50) begin
         @(negedge clock_i);
         n++;
      end
      if (o == HBF_OP_READ) chk(16'(n < 50), 16'h0001);
      rv = rdata_o;
      wait_rdy();
   endtask
   task automatic rd_chk(input logic [19:0] a, input logic [15:0] exp);
      run(HBF_OP_READ, a, 16'h0000);
      chk(rv, exp);
   endtask
   task automatic pd_cycle(input logic b);
      pd_req_i = 1;
      repeat (8) @(negedge clock_i);
      chk(16'({ready_o, ce_n_o, oe_n_o, we_n_o, rp_n}), 16'h000E);
      chk(dq_oe_n_o, 16'hFFFF);
      byte_mode_i = b;
      repeat (4) @(negedge clock_i);
      pd_req_i = 0;
      wait_rdy();
      chk(16'(byte_n_o), 16'(!b));
   endtask
   task automatic t_prog();
      run(HBF_OP_PROG, 20'h00005, 16'h1234);
      run(HBF_OP_PROG, 20'h00006, 16'hABCD);
      rd_chk(20'h00005, 16'h1234);
      rd_chk(20'h00006, 16'hABCD);
      rd_chk(20'h00007, 16'hFFFF);
      run(HBF_OP_CMD, 20'h00003, 16'h00FF);
      chk(16'(hbf_flash_model_inst.last_cmd), 16'h00FF);
   endtask
   task automatic t_byte();
      pd_cycle(1);
      rd_chk(20'h0000B, 16'h0012);
      rd_chk(20'h0000A, 16'h0034);
      run(HBF_OP_PROG, 20'h0000F, 16'h005A);
      rd_chk(20'h0000F, 16'h005A);
      rd_chk(20'h0000E, 16'h00FF);
      id_mode_i = 1;
      rd_chk(20'h00003, {8'h00, hbf_flash_model_inst.DEV_CODE[7:0]});
      rd_chk(20'h00001, {8'h00, hbf_flash_model_inst.MFR_CODE[7:0]});
      id_mode_i = 0;
   endtask
   task automatic t_word_id();
      pd_cycle(0);
      rd_chk(20'h00005, 16'h1234);
      id_mode_i = 1;
      repeat (3) @(negedge clock_i);
      chk(16'(id_hv), 16'h0001);
      rd_chk(20'h00000, hbf_flash_model_inst.MFR_CODE);
      rd_chk(20'h00001, hbf_flash_model_inst.DEV_CODE);
      id_mode_i = 0;
      {unl, unl_hv} = 2'b11;
      repeat (4) @(negedge clock_i);
      chk(16'({guard_n, rp_hv}), 16'h0003);
      {unl, unl_hv} = 2'b00;
      repeat (4) @(negedge clock_i);
      chk(16'({guard_n, rp_hv}), 16'h0000);
      chk(16'(hbf_flash_model_inst.early_writes), 16'h0000);
   endtask
   task automatic t_guard();
      run(HBF_OP_PROG, 20'h000F5, 16'h1111);
      rd_chk(20'h000F5, 16'hFFFF);
      chk(16'(hbf_flash_model_inst.status_w), 16'h0010);
      rst_n_i = 0;
      repeat (16) @(negedge clock_i);
      chk(16'({ce_n_o, we_n_o, rp_n}), 16'h0006);
      chk(16'(hbf_flash_model_inst.status_w), 16'h0000);
      rst_n_i = 1;
      unl_hv = 1;
      run(HBF_OP_PROG, 20'h000F6, 16'h2222);
      rd_chk(20'h000F6, 16'h2222);
      unl_hv = 0;
      unl = 1;
      run(HBF_OP_PROG, 20'h000F7, 16'h3333);
      rd_chk(20'h000F7, 16'h3333);
      vpp_low = 1;
      run(HBF_OP_PROG, 20'h00008, 16'h4444);
      rd_chk(20'h00008, 16'hFFFF);
      chk(16'(hbf_flash_model_inst.refused), 16'h0001);
      vpp_low = 0;
      unl = 0;
      chk(16'(hbf_flash_model_inst.early_writes), 16'h0000);
   endtask
   task automatic test_done();
      $display("Compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (16) @(negedge clock_i);
      chk(16'({ce_n_o, oe_n_o, we_n_o, rp_n}), 16'h000E);
      chk(dq_oe_n_o, 16'hFFFF);
      rst_n_i = 1;
      t_prog();
      t_byte();
      t_word_id();
      t_guard();
      test_done();
   end
   // Whole run needs a few hundred cycles; allow ample margin
   initial begin
      #(CLK_NS * 20000);
      fails++;
      test_done();
   end
endmodule
